/* File: fmdm_core.sv */
// two-tone packet modem digital core: hdlc framer both ways, kiss host uart,
// four-phase table lookup, receive clock recovery and carrier detect
// assumes clk_in at 64x the bit rate, table replies within the selected latency
//
// The implementer's own choices: the APB slave port and the placing of the registers.
module fmdm_core (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   input wire logic rx_data_in,
   input wire logic tx_data_in,
   input wire logic uart_rts_in,
   input wire logic uart_rx_in,
   input wire logic [3:0] lookup_nibble_in,
   input wire logic rx_clk_in,
   output logic rx_clk_out,
   output logic rx_clk_oe_out,
   input wire logic up_down_in,
   output logic up_down_out,
   output logic up_down_oe_out,
   output logic [5:0] lookup_index_out,
   output logic lookup_index_oe_out,
   output logic uart_tx_out,
   output logic uart_cts_out,
   output logic uart_dcd_out,
   output logic rx_error_out,
   output logic tx_error_out,
   output logic sending_out,
   output logic tx_clk_strobe_out,
   output logic [7:0] tx_dac_out,
   output logic [7:0] rx_fb_out,
   output logic irq_out
);
   import fmdm_pkg::*;

   // pin synchronisers, one vector of two flops
   logic [9:0] sync1_r;
   logic [9:0] sync2_r;
   logic rx_data_s, tx_data_s, rts_s, urx_s, rxclk_s, updn_s;
   logic [3:0] nib_s;
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sync1_r <= 10'h000;
         sync2_r <= 10'h000;
      end else begin
         sync1_r <= {rx_data_in, tx_data_in, uart_rts_in, uart_rx_in, rx_clk_in, up_down_in,
                     lookup_nibble_in};
         sync2_r <= sync1_r;
      end
   end
   assign {rx_data_s, tx_data_s, rts_s, urx_s, rxclk_s, updn_s, nib_s} = sync2_r;

   // registers
   logic [CTRL_W-1:0] ctrl_r;
   logic [INT_W-1:0] int_st_r;
   logic [INT_W-1:0] int_en_r;
   logic [INT_W-1:0] ev;
   logic [31:0] rd_mux;
   logic mapped, wr_acc;
   logic dcd_r;
   logic [3:0] score_r;
   logic hold_v_r, rxb_v_r;
   fmdm_txmode_type mode_r;

   assign mapped = (paddr_in == ADDR_CTRL) || (paddr_in == ADDR_STATUS) ||
                   (paddr_in == ADDR_INT_STATUS) || (paddr_in == ADDR_INT_ENABLE) ||
                   (paddr_in == ADDR_INT_CLEAR);
   assign wr_acc = psel_in && penable_in && pwrite_in;
   assign pready_out = 1'b1;
   assign pslverr_out = psel_in && penable_in && !mapped;
   always_comb begin
      rd_mux = 32'h0000_0000;
      unique case (paddr_in)
         ADDR_CTRL: rd_mux[CTRL_W-1:0] = ctrl_r;
         ADDR_STATUS: rd_mux[7:0] = {score_r, rxb_v_r, hold_v_r, mode_r == TM_DATA, dcd_r};
         ADDR_INT_STATUS: rd_mux[INT_W-1:0] = int_st_r;
         ADDR_INT_ENABLE: rd_mux[INT_W-1:0] = int_en_r;
         default: rd_mux = 32'h0000_0000;
      endcase
   end
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ctrl_r <= CTRL_RESET;
         int_en_r <= '0;
         int_st_r <= '0;
         prdata_out <= 32'h0000_0000;
      end else begin
         // read data is latched in the setup cycle so the slave never waits
         if (psel_in && !penable_in) prdata_out <= rd_mux;
         if (wr_acc && paddr_in == ADDR_CTRL) ctrl_r <= pwdata_in[CTRL_W-1:0];
         if (wr_acc && paddr_in == ADDR_INT_ENABLE) int_en_r <= pwdata_in[INT_W-1:0];
         // a new event wins over a clear in the same cycle
         if (wr_acc && paddr_in == ADDR_INT_CLEAR)
            int_st_r <= (int_st_r & ~pwdata_in[INT_W-1:0]) | ev;
         else
            int_st_r <= int_st_r | ev;
      end
   end
   assign irq_out = |(int_st_r & int_en_r);

   // four-phase lookup sequencer; all rates come from this one clock
   logic [1:0] phase_r;
   logic [1:0] cap_slot;
   logic [1:0] phase_nx;
   logic tx_tick, rx_tick;
   logic [3:0] tx_cnt_r;
   logic [2:0] hist_r;
   logic [3:0] rx_cnt_r;
   logic rx_bit;
   logic [3:0] txlo_r, rxlo_r;
   assign phase_nx = phase_r + 2'h1;
   // tx state moves just before its own phases, rx state just before its own
   assign tx_tick = (phase_r == PH_RX_LO);
   assign rx_tick = (phase_r == PH_TX_LO);
   assign cap_slot = phase_r - 2'h2 - {1'b0, ctrl_r[CTRL_LAT]};
   assign lookup_index_oe_out = 1'b1;
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         phase_r <= PH_TX_LO;
         lookup_index_out <= 6'h00;
         tx_clk_strobe_out <= 1'b0;
      end else begin
         phase_r <= phase_nx;
         tx_clk_strobe_out <= (phase_r == PH_RX_HI);
         unique case (phase_nx)
            PH_TX_LO: lookup_index_out <= {hist_r, tx_cnt_r[3:2], 1'b0};
            PH_TX_HI: lookup_index_out <= {hist_r, tx_cnt_r[3:2], 1'b1};
            PH_RX_LO: lookup_index_out <= {rx_cnt_r, rx_bit, 1'b0};
            PH_RX_HI: lookup_index_out <= {rx_cnt_r, rx_bit, 1'b1};
         endcase
      end
   end
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         txlo_r <= 4'h0;
         rxlo_r <= 4'h0;
         tx_dac_out <= 8'h00;
         rx_fb_out <= 8'h00;
      end else begin
         unique case (cap_slot)
            PH_TX_LO: txlo_r <= nib_s;
            PH_TX_HI: tx_dac_out <= {nib_s, txlo_r};
            PH_RX_LO: rxlo_r <= nib_s;
            PH_RX_HI: rx_fb_out <= {nib_s, rxlo_r};
         endcase
      end
   end

   // host uart and kiss decoder feeding a one-byte transmit hold
   logic [7:0] urx_byte;
   logic urx_v, urx_ferr;
   logic [7:0] hold_r;
   logic hold_end_r, kcmd_r, kesc_r, kdata_r;
   logic consume, push, push_end, tx_ovf;
   logic [7:0] kbyte;
   fmdm_uart_rx u_urx (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .line_in(urx_s),
      .x2_in(ctrl_r[CTRL_URX_X2]),
      .byte_out(urx_byte),
      .valid_out(urx_v),
      .ferr_out(urx_ferr)
   );
   always_comb begin
      kbyte = urx_byte;
      if (kesc_r && urx_byte == KISS_TFEND) kbyte = KISS_FEND;
      if (kesc_r && urx_byte == KISS_TFESC) kbyte = KISS_FESC;
   end
   assign push_end = urx_v && urx_byte == KISS_FEND && kdata_r;
   assign push = push_end || (urx_v && urx_byte != KISS_FEND && !kcmd_r &&
                              !(urx_byte == KISS_FESC && !kesc_r));
   assign tx_ovf = push && hold_v_r && !consume;
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         hold_r <= 8'h00;
         hold_v_r <= 1'b0;
         hold_end_r <= 1'b0;
         kcmd_r <= 1'b1;
         kesc_r <= 1'b0;
         kdata_r <= 1'b0;
         uart_cts_out <= 1'b0;
      end else begin
         uart_cts_out <= !hold_v_r;
         if (consume) hold_v_r <= 1'b0;
         if (push && !tx_ovf) begin
            hold_v_r <= 1'b1;
            hold_r <= kbyte;
            hold_end_r <= push_end;
         end
         if (urx_v) begin
            if (urx_byte == KISS_FEND) begin
               kcmd_r <= 1'b1;
               kdata_r <= 1'b0;
               kesc_r <= 1'b0;
            end else if (kcmd_r) begin
               kcmd_r <= 1'b0;
            end else if (urx_byte == KISS_FESC && !kesc_r) begin
               kesc_r <= 1'b1;
            end else begin
               kesc_r <= 1'b0;
               kdata_r <= 1'b1;
            end
         end
      end
   end

   // hdlc transmitter: flags between frames, zero stuffing after five ones
   logic bit_tick, tx_bit, load, underrun, mod_bit;
   logic [2:0] fbit_r;
   logic [3:0] dbit_r;
   logic [2:0] ones_r;
   logic [7:0] sh_r;
   assign bit_tick = tx_tick && tx_cnt_r == 4'(TXCLK_PER_BIT - 1);
   always_comb begin
      tx_bit = 1'b0;
      load = 1'b0;
      unique case (mode_r)
         TM_FLAG: tx_bit = HDLC_FLAG[fbit_r];
         TM_DATA: begin
            if (ones_r == 3'h5) begin
               tx_bit = 1'b0;
            end else if (dbit_r == 4'h8) begin
               load = hold_v_r && !hold_end_r;
               tx_bit = load & hold_r[0];
            end else begin
               tx_bit = sh_r[dbit_r[2:0]];
            end
         end
      endcase
   end
   assign consume = bit_tick && hold_v_r &&
      ((mode_r == TM_FLAG && fbit_r == 3'h7 && hold_end_r) ||
       (mode_r == TM_DATA && ones_r != 3'h5 && dbit_r == 4'h8));
   assign underrun = bit_tick && mode_r == TM_DATA && ones_r != 3'h5 &&
                     dbit_r == 4'h8 && !hold_v_r;
   assign mod_bit = ctrl_r[CTRL_TX_EXT] ? tx_data_s : tx_bit;
   assign sending_out = (mode_r == TM_DATA);
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         mode_r <= TM_FLAG;
         fbit_r <= 3'h0;
         dbit_r <= 4'h8;
         ones_r <= 3'h0;
         sh_r <= 8'h00;
         tx_cnt_r <= 4'h0;
         hist_r <= 3'h0;
      end else begin
         if (tx_tick) tx_cnt_r <= tx_cnt_r + 4'h1;
         if (bit_tick) begin
            hist_r <= {hist_r[1:0], mod_bit};
            unique case (mode_r)
               TM_FLAG: begin
                  fbit_r <= fbit_r + 3'h1;
                  if (fbit_r == 3'h7 && hold_v_r && !hold_end_r) begin
                     mode_r <= TM_DATA;
                     dbit_r <= 4'h8;
                     ones_r <= 3'h0;
                  end
               end
               TM_DATA: begin
                  if (ones_r == 3'h5) begin
                     ones_r <= 3'h0;
                  end else if (dbit_r == 4'h8 && !load) begin
                     mode_r <= TM_FLAG;
                     fbit_r <= 3'h1;
                     ones_r <= 3'h0;
                  end else begin
                     if (load) sh_r <= hold_r;
                     dbit_r <= load ? 4'h1 : dbit_r + 4'h1;
                     ones_r <= tx_bit ? ones_r + 3'h1 : 3'h0;
                  end
               end
            endcase
         end
      end
   end

   // clock recovery: 16 ticks per bit, nudged at each data transition that does not land on count 0
   logic rx_prev_r, adv_r, ret_r, edge_det, dir, rclk, rclk_prev_r, samp;
   logic near_edge;
   assign rx_bit = ctrl_r[CTRL_LOOP] ? hist_r[0] : rx_data_s;
   assign edge_det = (rx_bit != rx_prev_r);
   assign dir = ctrl_r[CTRL_UPDN_EXT] ? updn_s : rx_cnt_r[3];
   assign near_edge = (rx_cnt_r == 4'hf) || (rx_cnt_r <= 4'h1);
   assign rclk = ctrl_r[CTRL_RXCLK_EXT] ? rxclk_s : rx_cnt_r[3];
   assign samp = rclk && !rclk_prev_r;
   assign rx_clk_out = rx_cnt_r[3];
   assign rx_clk_oe_out = !ctrl_r[CTRL_RXCLK_EXT];
   assign up_down_oe_out = !ctrl_r[CTRL_UPDN_EXT];
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rx_prev_r <= 1'b0;
         rx_cnt_r <= 4'h0;
         adv_r <= 1'b0;
         ret_r <= 1'b0;
         up_down_out <= 1'b0;
         score_r <= 4'h0;
         dcd_r <= 1'b0;
         rclk_prev_r <= 1'b0;
      end else begin
         rx_prev_r <= rx_bit;
         rclk_prev_r <= rclk;
         dcd_r <= (score_r >= LOCK_THRESH);
         if (rx_tick) begin
            rx_cnt_r <= rx_cnt_r + (adv_r ? 4'h2 : (ret_r ? 4'h0 : 4'h1));
            adv_r <= 1'b0;
            ret_r <= 1'b0;
         end
         // a transition landing on the tick keeps its correction for the next one
         if (edge_det && rx_cnt_r != 4'h0) begin
            adv_r <= dir;
            ret_r <= !dir;
         end
         if (edge_det) begin
            up_down_out <= rx_cnt_r[3];
            if (near_edge && score_r != 4'hf) score_r <= score_r + 4'h1;
            if (!near_edge && score_r != 4'h0) score_r <= score_r - 4'h1;
         end
      end
   end
   assign uart_dcd_out = dcd_r;

   // hdlc receiver: 7-bit lookahead lets a closing flag be dropped cleanly
   logic [7:0] raw_r;
   logic [15:0] d_r;
   logic [3:0] dcnt_r;
   logic rin_r, rbytes_r, r_stuff, r_flag, r_abort, frame_end, rx_err;
   logic [7:0] rxb_r;
   logic byte_done, rx_ovr;
   assign r_stuff = !rx_bit && raw_r[7:3] == 5'h1f && !raw_r[2];
   assign r_flag = !rx_bit && raw_r[7:2] == 6'h3f && !raw_r[1];
   assign r_abort = rx_bit && raw_r[7:2] == 6'h3f;
   assign byte_done = samp && rin_r && !r_abort && !r_flag && !r_stuff && dcnt_r == 4'he;
   assign frame_end = samp && r_flag && rin_r && dcnt_r == 4'h7 && rbytes_r;
   assign rx_err = (samp && rin_r && ((r_flag && dcnt_r != 4'h7) || r_abort)) || rx_ovr;
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         raw_r <= 8'h00;
         d_r <= 16'h0000;
         dcnt_r <= 4'h0;
         rin_r <= 1'b0;
         rbytes_r <= 1'b0;
      end else if (samp) begin
         raw_r <= {rx_bit, raw_r[7:1]};
         if (r_abort) begin
            rin_r <= 1'b0;
         end else if (r_flag) begin
            rin_r <= 1'b1;
            dcnt_r <= 4'h0;
            rbytes_r <= 1'b0;
         end else if (!r_stuff && rin_r) begin
            d_r <= {rx_bit, d_r[15:1]};
            dcnt_r <= byte_done ? 4'h7 : dcnt_r + 4'h1;
            if (byte_done) rbytes_r <= 1'b1;
         end
      end
   end

   // kiss encoder toward the host uart
   logic utx_busy, utx_start, open_r, cmd_pend_r, esc_pend_r, end_pend_r;
   logic [7:0] esc_code_r, utx_byte;
   assign rx_ovr = byte_done && rxb_v_r;
   assign utx_start = !utx_busy && rts_s &&
                      (esc_pend_r || rxb_v_r || cmd_pend_r || end_pend_r);
   always_comb begin
      if (esc_pend_r) utx_byte = esc_code_r;
      else if (rxb_v_r && !open_r) utx_byte = KISS_FEND;
      else if (cmd_pend_r) utx_byte = KISS_CMD_DATA;
      else if (rxb_v_r && (rxb_r == KISS_FEND || rxb_r == KISS_FESC)) utx_byte = KISS_FESC;
      else if (rxb_v_r) utx_byte = rxb_r;
      else utx_byte = KISS_FEND;
   end
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rxb_r <= 8'h00;
         rxb_v_r <= 1'b0;
         open_r <= 1'b0;
         cmd_pend_r <= 1'b0;
         esc_pend_r <= 1'b0;
         end_pend_r <= 1'b0;
         esc_code_r <= 8'h00;
      end else begin
         if (utx_start) begin
            if (esc_pend_r) begin
               esc_pend_r <= 1'b0;
            end else if (rxb_v_r && !open_r) begin
               open_r <= 1'b1;
               cmd_pend_r <= 1'b1;
            end else if (cmd_pend_r) begin
               cmd_pend_r <= 1'b0;
            end else if (rxb_v_r) begin
               rxb_v_r <= 1'b0;
               esc_pend_r <= (rxb_r == KISS_FEND) || (rxb_r == KISS_FESC);
               esc_code_r <= (rxb_r == KISS_FEND) ? KISS_TFEND : KISS_TFESC;
            end else begin
               end_pend_r <= 1'b0;
               open_r <= 1'b0;
            end
         end
         if (byte_done && !rxb_v_r) begin
            rxb_r <= d_r[9:2];
            rxb_v_r <= 1'b1;
         end
         if (frame_end || (rx_err && open_r)) end_pend_r <= 1'b1;
      end
   end
   fmdm_uart_tx u_utx (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .start_in(utx_start),
      .byte_in(utx_byte),
      .x2_in(ctrl_r[CTRL_UTX_X2]),
      .line_out(uart_tx_out),
      .busy_out(utx_busy)
   );

   // events and error strobes
   assign ev[INT_RX_ERR] = rx_err;
   assign ev[INT_TX_ERR] = underrun || tx_ovf || urx_ferr;
   assign ev[INT_FRAME] = frame_end;
   assign ev[INT_DCD] = dcd_r != (score_r >= LOCK_THRESH);
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rx_error_out <= 1'b0;
         tx_error_out <= 1'b0;
      end else begin
         rx_error_out <= ev[INT_RX_ERR];
         tx_error_out <= ev[INT_TX_ERR];
      end
   end
endmodule : fmdm_core

/* File: fmdm_pkg.sv */
// constants shared by the two-tone packet modem digital core and its uart halves
// assumes one master clock at 64x the symbol rate; registers sit on a 32-bit apb slave
package fmdm_pkg;
   localparam int CLK_PER_TXCLK = 4;
   localparam int TXCLK_PER_BIT = 16;
   localparam int UTX_DIV_X1 = 64;
   localparam int UTX_DIV_X2 = 32;
   localparam int URX_SMP_X1 = 8;
   localparam int URX_SMP_X2 = 4;
   localparam logic [3:0] URX_VOTE_MIN = 4'h5;
   localparam logic [3:0] LOCK_THRESH = 4'hc;
   // lookup phases in cycle order
   localparam logic [1:0] PH_TX_LO = 2'h0;
   localparam logic [1:0] PH_TX_HI = 2'h1;
   localparam logic [1:0] PH_RX_LO = 2'h2;
   localparam logic [1:0] PH_RX_HI = 2'h3;
   localparam logic [7:0] HDLC_FLAG = 8'h7e;
   localparam logic [7:0] KISS_FEND = 8'hc0;
   localparam logic [7:0] KISS_FESC = 8'hdb;
   localparam logic [7:0] KISS_TFEND = 8'hdc;
   localparam logic [7:0] KISS_TFESC = 8'hdd;
   localparam logic [7:0] KISS_CMD_DATA = 8'h00;
   // register byte addresses
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_INT_STATUS = 8'h08;
   localparam logic [7:0] ADDR_INT_ENABLE = 8'h0c;
   localparam logic [7:0] ADDR_INT_CLEAR = 8'h10;
   // control fields
   localparam int CTRL_LAT = 0;
   localparam int CTRL_UTX_X2 = 1;
   localparam int CTRL_URX_X2 = 2;
   localparam int CTRL_RXCLK_EXT = 3;
   localparam int CTRL_UPDN_EXT = 4;
   localparam int CTRL_LOOP = 5;
   localparam int CTRL_TX_EXT = 6;
   localparam int CTRL_W = 7;
   localparam logic [6:0] CTRL_RESET = 7'h00;
   // interrupt fields
   localparam int INT_RX_ERR = 0;
   localparam int INT_TX_ERR = 1;
   localparam int INT_FRAME = 2;
   localparam int INT_DCD = 3;
   localparam int INT_W = 4;
   typedef enum logic {TM_FLAG, TM_DATA} fmdm_txmode_type;
endpackage : fmdm_pkg

/* File: fmdm_uart_tx.sv */
// uart transmitter, 8n1, bit period of 64 or 32 master clocks
// assumes the caller only pulses start while busy is low
module fmdm_uart_tx (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic start_in,
   input wire logic [7:0] byte_in,
   input wire logic x2_in,
   output logic line_out,
   output logic busy_out
);
   import fmdm_pkg::*;
   logic [5:0] tick_r;
   logic [3:0] bit_r;
   logic [9:0] sh_r;
   logic [5:0] period;

   assign period = x2_in ? 6'(UTX_DIV_X2 - 1) : 6'(UTX_DIV_X1 - 1);
   assign busy_out = (bit_r != 4'h0);
   assign line_out = sh_r[0];

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         tick_r <= 6'h00;
         bit_r <= 4'h0;
         sh_r <= 10'h3ff;
      end else if (start_in && !busy_out) begin
         sh_r <= {1'b1, byte_in, 1'b0};
         bit_r <= 4'ha;
         tick_r <= period;
      end else if (busy_out) begin
         if (tick_r == 6'h00) begin
            sh_r <= {1'b1, sh_r[9:1]};
            bit_r <= bit_r - 4'h1;
            tick_r <= period;
         end else begin
            tick_r <= tick_r - 6'h01;
         end
      end
   end
endmodule : fmdm_uart_tx

/* File: fmdm_uart_rx.sv */
// uart receiver, 8n1, eight samples per bit decided by majority
// assumes line_in is already synchronised to clk_in
module fmdm_uart_rx (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic line_in,
   input wire logic x2_in,
   output logic [7:0] byte_out,
   output logic valid_out,
   output logic ferr_out
);
   import fmdm_pkg::*;
   logic [2:0] div_r;
   logic [2:0] smp_r;
   logic [3:0] bit_r;
   logic [3:0] ones_r;
   logic [3:0] ones_all;
   logic vote;

   assign ones_all = ones_r + {3'h0, line_in};
   assign vote = (ones_all >= URX_VOTE_MIN);

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         div_r <= 3'h0;
         smp_r <= 3'h0;
         bit_r <= 4'h0;
         ones_r <= 4'h0;
         byte_out <= 8'h00;
         valid_out <= 1'b0;
         ferr_out <= 1'b0;
      end else begin
         valid_out <= 1'b0;
         ferr_out <= 1'b0;
         if (bit_r == 4'h0) begin
            // start window opens on the first low sample
            if (!line_in) begin
               bit_r <= 4'h1;
               div_r <= 3'h0;
               smp_r <= 3'h0;
               ones_r <= 4'h0;
            end
         end else if (div_r != 3'h0) begin
            div_r <= div_r - 3'h1;
         end else begin
            div_r <= x2_in ? 3'(URX_SMP_X2 - 1) : 3'(URX_SMP_X1 - 1);
            smp_r <= smp_r + 3'h1;
            ones_r <= ones_all;
            if (smp_r == 3'h7) begin
               ones_r <= 4'h0;
               if (bit_r == 4'h1) begin
                  bit_r <= vote ? 4'h0 : 4'h2;
               end else if (bit_r == 4'ha) begin
                  valid_out <= vote;
                  ferr_out <= !vote;
                  bit_r <= 4'h0;
               end else begin
                  byte_out <= {vote, byte_out[7:1]};
                  bit_r <= bit_r + 4'h1;
               end
            end
         end
      end
   end
endmodule : fmdm_uart_rx

/* File: fmdm_core_monitor.sv */
// port timing checker for the modem core
// bound to fmdm_core, sees its ports only
module fmdm_core_monitor
   import fmdm_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic rx_clk_oe_out,
   input wire logic up_down_oe_out,
   input wire logic [5:0] lookup_index_out,
   input wire logic uart_tx_out,
   input wire logic rx_error_out,
   input wire logic tx_clk_strobe_out,
   input wire logic [7:0] tx_dac_out,
   input wire logic [7:0] rx_fb_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   logic wr;
   logic s;
   logic [5:0] i;
   assign wr = psel_in && penable_in && pwrite_in && paddr_in == ADDR_CTRL;
   assign s = tx_clk_strobe_out;
   assign i = lookup_index_out;
   AST_STROBE: assert property (s |=> !s [*3] ##1 s)
      else $error("strobe spacing");
   AST_PHASE: assert property (s |-> !i[0] ##1 i[0] ##1 !i[0] ##1 i[0])
      else $error("lookup phase order");
   AST_DAC: assert property ($changed(tx_dac_out) |-> s || $past(s))
      else $error("dac loaded mid cycle");
   AST_FB: assert property ($changed(rx_fb_out) |-> $past(s, 2) || $past(s, 3))
      else $error("feedback loaded mid cycle");
   AST_RXCLK_OE: assert property ($changed(rx_clk_oe_out) |-> $past(wr))
      else $error("rx clock enable moved");
   AST_UPDN_OE: assert property ($changed(up_down_oe_out) |-> $past(wr))
      else $error("up down enable moved");
   AST_UART_START: assert property ($fell(uart_tx_out) |=> !uart_tx_out [*8])
      else $error("uart start bit short");
   AST_RX_ERR: assert property (rx_error_out |=> !rx_error_out)
      else $error("rx error not a pulse");
endmodule : fmdm_core_monitor

bind fmdm_core fmdm_core_monitor u_mon (.*);

/* File: fmdm_table_model.sv */
// lookup table partner: one nibble per index
// lat_in picks a reply in the index cycle or the next
module fmdm_table_model (
   input wire logic clk_in,
   input wire logic lat_in,
   input wire logic [5:0] index_in,
   output logic [3:0] nibble_out
);
   logic [3:0] late_r;
   // hi differs from lo in bit 3 only, so a wrong phase shows
   function automatic logic [3:0] fmdm_tab(input logic [5:0] x);
      return x[5:2] ^ {x[0], 3'h0};
   endfunction : fmdm_tab
   always_ff @(posedge clk_in) late_r <= fmdm_tab(index_in);
   assign nibble_out = lat_in ? late_r : fmdm_tab(index_in);
endmodule : fmdm_table_model

/* File: test_fsk_modem_hdlc_uart_digital.sv */
// self-checking bench for the modem core
// table partner answers lookups; the checker binds itself
module test_fsk_modem_hdlc_uart_digital;
   timeunit 1ns;
   timeprecision 1ns;
   import fmdm_pkg::*;
   logic clk_in = 0, rst_n_in = 0, psel_in = 0, penable_in = 0, pwrite_in = 0;
   logic [7:0] paddr_in = 0, tx_dac_out, rx_fb_out;
   logic [31:0] pwdata_in = 0, prdata_out, rd, c;
   logic rx_data_in = 0, tx_data_in = 0, uart_rts_in = 1, uart_rx_in = 1;
   logic rx_clk_in = 0, up_down_in = 0, lat = 0, err, sent = 0, utx_low = 0;
   logic [3:0] lookup_nibble_in;
   logic [5:0] lookup_index_out;
   logic pready_out, pslverr_out, rx_clk_out, rx_clk_oe_out, up_down_out;
   logic up_down_oe_out, lookup_index_oe_out, uart_tx_out, uart_cts_out, uart_dcd_out;
   logic rx_error_out, tx_error_out, sending_out, tx_clk_strobe_out, irq_out;
   logic [7:0] fr [4] = '{KISS_FEND, KISS_CMD_DATA, 8'ha5, KISS_FEND};
   int num_errors = 0, n_checks = 0, cyc = 0;
   always #50 clk_in = ~clk_in;
   fmdm_table_model u_tab (.clk_in, .lat_in(lat), .index_in(lookup_index_out),
      .nibble_out(lookup_nibble_in));
   fmdm_core DUT (.*);
   function automatic logic [3:0] hi_of(input logic [3:0] lo);
      return lo ^ 4'h8;
   endfunction : hi_of
   task automatic check(input string nm, input logic [31:0] seen, exp);
      n_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value %s exp %h seen %h", nm, exp, seen);
      end
   endtask : check
   task automatic finish_test();
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : finish_test
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel_in <= 1;
      pwrite_in <= w;
      paddr_in <= a;
      pwdata_in <= d;
      @(posedge clk_in);
      penable_in <= 1;
      do @(posedge clk_in); while (pready_out !== 1'b1);
      rd = prdata_out;
      err = pslverr_out;
      psel_in <= 0;
      penable_in <= 0;
      @(posedge clk_in);
   endtask : apb
   // 8n1 at one bit per 64 clocks, only while the device accepts
   task automatic host_byte(input logic [7:0] b);
      while (uart_cts_out !== 1'b1) @(posedge clk_in);
      for (int k = 0; k < 10; k++) begin
         uart_rx_in <= k == 0 ? 1'b0 : k == 9 ? 1'b1 : b[k - 1];
         repeat (64) @(posedge clk_in);
      end
   endtask : host_byte
   always @(posedge clk_in) begin
      cyc++;
      if (sending_out === 1'b1) sent <= 1;
      if (uart_tx_out === 1'b0) utx_low <= 1;
      if (cyc == 60000) begin
         num_errors++;
         finish_test();
      end
   end
   initial begin
      c = $urandom(32'h370d);
      repeat (12) @(posedge clk_in);
      rst_n_in <= 1;
      @(posedge clk_in);
      apb(0, ADDR_CTRL, 0);
      check("ctrl reset", rd, 0);
      apb(0, 8'h14, 0);
      check("unmapped", err, 1);
      $display("test reset done");
      for (int l = 0; l < 2; l++) begin
         c = ($urandom & 32'h0000_007e) | 32'(l);
         apb(1, ADDR_CTRL, c);
         lat <= c[0];
         check("rxclk oe", rx_clk_oe_out, !c[CTRL_RXCLK_EXT]);
         check("updn oe", up_down_oe_out, !c[CTRL_UPDN_EXT]);
         for (int k = 0; k < 24; k++) begin
            rx_data_in <= ($urandom % 4) != 0;
            tx_data_in <= 1'($urandom);
            up_down_in <= 1'($urandom);
            for (int j = 0; j < 64; j++) begin
               if (j % 32 == 0) rx_clk_in <= ~rx_clk_in;
               @(posedge clk_in);
               if (k > 0 && tx_clk_strobe_out) begin
                  check("dac", tx_dac_out[7:4], hi_of(tx_dac_out[3:0]));
                  check("fb", rx_fb_out[7:4], hi_of(rx_fb_out[3:0]));
               end
            end
         end
         $display("test latency %0d done", l);
      end
      // loop back a host frame to raise the frame interrupt
      apb(1, ADDR_CTRL, 32'h0000_0020);
      lat <= 0;
      rx_data_in <= 0;
      apb(1, ADDR_INT_CLEAR, 32'h0000_000f);
      apb(1, ADDR_INT_ENABLE, 32'h0000_0004);
      foreach (fr[m]) host_byte(fr[m]);
      for (int w = 0; w < 20000 && irq_out !== 1'b1; w++) @(posedge clk_in);
      check("frame irq", irq_out, 1);
      check("sending", sent, 1);
      apb(0, ADDR_INT_STATUS, 0);
      check("frame status", rd[INT_FRAME], 1);
      // the closing host byte arrives after the single data byte has gone out
      check("tx err", rd[INT_TX_ERR], 1);
      check("host uart", utx_low, 1);
      apb(1, ADDR_INT_ENABLE, 0);
      check("masked irq", irq_out, 0);
      apb(1, ADDR_INT_CLEAR, 32'h0000_0004);
      apb(0, ADDR_INT_STATUS, 0);
      check("cleared", rd[INT_FRAME], 0);
      $display("test interrupt done");
      finish_test();
   end
endmodule : test_fsk_modem_hdlc_uart_digital
